// [include/dbu_map.vh]
// register slots, field positions and codes of the debug breakpoint unit
`ifndef DBU_MAP_VH
`define DBU_MAP_VH
// debug register slot numbers on the move-port
`define DBU_SLOT_BP0 3'h0
`define DBU_SLOT_BP1 3'h1
`define DBU_SLOT_BP2 3'h2
`define DBU_SLOT_BP3 3'h3
`define DBU_SLOT_LEG_STAT 3'h4
`define DBU_SLOT_LEG_CTRL 3'h5
`define DBU_SLOT_STATUS 3'h6
`define DBU_SLOT_CONTROL 3'h7
// status register fields
`define DBU_ST_RA_HIT 13
`define DBU_ST_SS_HIT 14
`define DBU_ST_TS_HIT 15
`define DBU_ST_WR_MASK 32'h0000e00f
`define DBU_ST_RESET 32'hffff0ff0
// control register fields
`define DBU_CT_COMPAT_L 8
`define DBU_CT_COMPAT_G 9
`define DBU_CT_GUARD 13
`define DBU_CT_FIELD_LO 16
`define DBU_CT_WR_MASK 32'hffff23ff
`define DBU_CT_RESET 32'h00000400
`define DBU_CT_FIXED 32'h00000400
// breakpoint type codes
`define DBU_TYPE_EXEC 2'h0
`define DBU_TYPE_DWR 2'h1
`define DBU_TYPE_IO 2'h2
`define DBU_TYPE_DRW 2'h3
// size codes
`define DBU_SIZE_1 2'h0
`define DBU_SIZE_2 2'h1
`define DBU_SIZE_4 2'h3
// exception vectors and extra bit positions
`define DBU_VEC_DEBUG 8'h01
`define DBU_VEC_BREAK 8'h03
`define DBU_OP_BREAK 8'hcc
`define DBU_CR4_EXT_BIT 3
`define DBU_FLAGS_TRAP_BIT 8
`endif

// [logic/dbu_sync.v]
// two flip-flop synchroniser for the asynchronous reset release
`timescale 1ns/1ns
module dbu_sync (
    input wire clock, // core clock
    input wire reset_n, // asynchronous reset, active low
    output reg rst_sync_n // reset release on the clock
);
    reg stage_reg;

    // first stage is read only by the second
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_reg <= 1'b1;
            rst_sync_n <= stage_reg;
        end
    end
endmodule // dbu_sync

// [logic/dbu_cmp.v]
// one breakpoint comparator: address window and cycle type match
`timescale 1ns/1ns
`include "dbu_map.vh"
module dbu_cmp (
    input wire [31:0] bp_addr, // breakpoint linear address
    input wire [1:0] bp_type, // type field
    input wire [1:0] bp_size, // size field
    input wire io_ext_on, // io breakpoints legal
    input wire fetch_valid, // instruction about to execute
    input wire [31:0] fetch_addr, // its linear address
    input wire cyc_valid, // data or io cycle done
    input wire cyc_write, // cycle is a write
    input wire cyc_io, // cycle is an io cycle
    input wire [31:0] cyc_addr, // cycle linear address
    input wire [2:0] cyc_len, // bytes in cycle, 1 to 4
    output wire exec_hit, // instruction breakpoint match
    output wire data_hit // data or io breakpoint match
);
    reg [31:0] mask;
    wire [31:0] cyc_last;
    wire overlap;

    // size picks how many low address bits the data and io match ignores
    always @* begin
        case (bp_size)
            `DBU_SIZE_2: mask = 32'hfffffffe;
            `DBU_SIZE_4: mask = 32'hfffffffc;
            default: mask = 32'hffffffff;
        endcase
    end

    assign cyc_last = cyc_addr + {29'h0, cyc_len} - 32'h1;
    // the first or the last byte of the cycle falls inside the breakpoint window
    assign overlap = ((cyc_addr & mask) == (bp_addr & mask)) ||
                     ((cyc_last & mask) == (bp_addr & mask));

    // type field selects which cycle counts
    assign exec_hit = fetch_valid && (bp_type == `DBU_TYPE_EXEC) &&
                      (fetch_addr == bp_addr);
    assign data_hit = cyc_valid && overlap && (
        ((bp_type == `DBU_TYPE_DWR) && cyc_write && !cyc_io) ||
        ((bp_type == `DBU_TYPE_DRW) && !cyc_io) ||
        ((bp_type == `DBU_TYPE_IO) && cyc_io && io_ext_on));
endmodule // dbu_cmp

// [logic/dbu_unit.v]
// debug breakpoint unit: address comparators, status and control
`timescale 1ns/1ns
`include "dbu_map.vh"
module dbu_unit (
    input wire clock, // core clock, 125 MHz
    input wire reset_n, // asynchronous reset, active low
    input wire mov_valid, // debug register move decoded
    input wire mov_write, // 1 store into register, 0 load
    input wire [2:0] mov_slot, // debug register number
    input wire [31:0] mov_wdata, // data for a store
    input wire [31:0] cr4_value, // control_reg_four from the core
    input wire [31:0] flags_word, // flags word of the retiring instr
    input wire fetch_valid, // instruction about to execute
    input wire [31:0] fetch_addr, // its linear address
    input wire [7:0] fetch_opcode, // its first opcode byte
    input wire retire_valid, // instruction completed successfully
    input wire cyc_valid, // data or io cycle completed
    input wire cyc_write, // cycle is a write
    input wire cyc_io, // cycle is io
    input wire [31:0] cyc_addr, // cycle linear address
    input wire [2:0] cyc_len, // cycle length in bytes
    input wire task_switch, // task switch completed
    input wire task_trap_flag, // new task_state_block trap flag
    output reg [31:0] mov_rdata, // data for a load
    output reg mov_done, // load or store carried out
    output reg undef_opcode, // undefined-opcode exception pulse
    output reg debug_fault, // vector 01h fault pulse
    output reg debug_trap, // vector 01h trap pulse
    output reg break_trap, // vector 03h trap pulse
    output reg [7:0] exc_vector // vector of the last debug or breakpoint exception
);
    wire rst_n;
    reg [31:0] bp_addr_reg [0:3];
    reg [31:0] status_reg;
    reg [31:0] control_reg;
    reg pend_trap_reg;
    wire io_break_ext_on;
    wire [3:0] exec_hit;
    wire [3:0] data_hit;
    wire [3:0] bp_enabled;
    wire [3:0] exec_fire;
    wire [3:0] data_fire;
    wire legacy_slot;
    wire guard_hit;
    wire [2:0] eff_slot;
    wire single_step;
    wire task_trap;
    wire trap_now;
    wire fault_now;
    wire any_exc;
    reg [31:0] read_value;
    reg [31:0] status_next;
    reg [31:0] control_next;
    integer i;

    dbu_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .rst_sync_n(rst_n)
    );

    assign io_break_ext_on = cr4_value[`DBU_CR4_EXT_BIT];

    // four comparators, one per address register
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_cmp
            dbu_cmp u_cmp (
                .bp_addr(bp_addr_reg[g]),
                .bp_type(control_reg[`DBU_CT_FIELD_LO + 4 * g +: 2]),
                .bp_size(control_reg[`DBU_CT_FIELD_LO + 4 * g + 2 +: 2]),
                .io_ext_on(io_break_ext_on),
                .fetch_valid(fetch_valid),
                .fetch_addr(fetch_addr),
                .cyc_valid(cyc_valid),
                .cyc_write(cyc_write),
                .cyc_io(cyc_io),
                .cyc_addr(cyc_addr),
                .cyc_len(cyc_len),
                .exec_hit(exec_hit[g]),
                .data_hit(data_hit[g])
            );
            // either the per-task or the all-task bit enables it
            assign bp_enabled[g] = control_reg[2 * g] |
                                   control_reg[2 * g + 1];
        end
    endgenerate

    assign exec_fire = exec_hit & bp_enabled;
    assign data_fire = data_hit & bp_enabled;

    // legacy slots and the access guard
    assign legacy_slot = (mov_slot == `DBU_SLOT_LEG_STAT) ||
                         (mov_slot == `DBU_SLOT_LEG_CTRL);
    assign guard_hit = mov_valid && control_reg[`DBU_CT_GUARD];
    assign eff_slot = (legacy_slot && !io_break_ext_on) ?
                      (mov_slot + 3'h2) : mov_slot;

    // data hits are held until the instruction retires, then trapped
    assign single_step = retire_valid &&
                         flags_word[`DBU_FLAGS_TRAP_BIT];
    assign task_trap = task_switch && task_trap_flag;
    assign trap_now = (retire_valid && (pend_trap_reg ||
                       (|data_fire))) || single_step || task_trap;
    assign fault_now = guard_hit || (|exec_fire);
    assign any_exc = trap_now || fault_now;

    // read mux over the effective slot
    always @* begin
        case (eff_slot)
            `DBU_SLOT_BP0: read_value = bp_addr_reg[0];
            `DBU_SLOT_BP1: read_value = bp_addr_reg[1];
            `DBU_SLOT_BP2: read_value = bp_addr_reg[2];
            `DBU_SLOT_BP3: read_value = bp_addr_reg[3];
            `DBU_SLOT_STATUS: read_value = status_reg;
            `DBU_SLOT_CONTROL: read_value = control_reg;
            default: read_value = 32'h00000000;
        endcase
    end

    // status: software writes, hardware sets; set wins over clear
    always @* begin
        status_next = status_reg;
        if (mov_valid && mov_write && !guard_hit &&
            !(legacy_slot && io_break_ext_on) &&
            eff_slot == `DBU_SLOT_STATUS) begin
            status_next = (mov_wdata & `DBU_ST_WR_MASK) |
                          (`DBU_ST_RESET & ~`DBU_ST_WR_MASK);
        end
        status_next[3:0] = status_next[3:0] | exec_hit | data_hit;
        if (guard_hit) begin
            status_next[`DBU_ST_RA_HIT] = 1'b1;
        end
        if (single_step) begin
            status_next[`DBU_ST_SS_HIT] = 1'b1;
        end
        if (task_trap) begin
            status_next[`DBU_ST_TS_HIT] = 1'b1;
        end
    end

    // control: stores, task-switch clear, guard clear on debug exception
    always @* begin
        control_next = control_reg;
        if (mov_valid && mov_write && !guard_hit &&
            !(legacy_slot && io_break_ext_on) &&
            eff_slot == `DBU_SLOT_CONTROL) begin
            control_next = (mov_wdata & `DBU_CT_WR_MASK) |
                           `DBU_CT_FIXED;
        end
        if (task_switch) begin
            for (i = 0; i < 4; i = i + 1) begin
                control_next[2 * i] = 1'b0;
            end
        end
        if (any_exc) begin
            control_next[`DBU_CT_GUARD] = 1'b0;
        end
    end

    // register state
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                bp_addr_reg[i] <= 32'h00000000;
            end
            status_reg <= `DBU_ST_RESET;
            control_reg <= `DBU_CT_RESET;
            pend_trap_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            control_reg <= control_next;
            pend_trap_reg <= retire_valid ? 1'b0 :
                             (pend_trap_reg | (|data_fire));
            if (mov_valid && mov_write && !guard_hit &&
                eff_slot <= `DBU_SLOT_BP3) begin
                bp_addr_reg[eff_slot[1:0]] <= mov_wdata;
            end
        end
    end

    // move answers and exception pulses
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mov_rdata <= 32'h00000000;
            mov_done <= 1'b0;
            undef_opcode <= 1'b0;
            debug_fault <= 1'b0;
            debug_trap <= 1'b0;
            break_trap <= 1'b0;
            exc_vector <= 8'h00;
        end else begin
            // guard fault preempts the move; legacy slot may be undefined
            mov_done <= mov_valid && !guard_hit &&
                        !(legacy_slot && io_break_ext_on);
            undef_opcode <= mov_valid && !guard_hit &&
                            legacy_slot && io_break_ext_on;
            if (mov_valid && !mov_write) begin
                mov_rdata <= read_value;
            end
            debug_fault <= fault_now;
            debug_trap <= trap_now;
            break_trap <= retire_valid &&
                          (fetch_opcode == `DBU_OP_BREAK);
            if (fault_now || trap_now) begin
                exc_vector <= `DBU_VEC_DEBUG;
            end else if (retire_valid &&
                         fetch_opcode == `DBU_OP_BREAK) begin
                exc_vector <= `DBU_VEC_BREAK;
            end
        end
    end
endmodule // dbu_unit

// [dv/dbu_unit_props.sv]
// assertions on the ports of the debug breakpoint unit
`timescale 1ns/1ns
module dbu_unit_props (
    input wire clock, // core clock
    input wire reset_n, // reset, active low
    input wire mov_valid, // move decoded
    input wire [2:0] mov_slot, // register number
    input wire [31:0] cr4_value, // extension bit 3
    input wire [31:0] flags_word, // trap flag bit 8
    input wire [7:0] fetch_opcode, // first opcode byte
    input wire retire_valid, // instruction retired
    input wire task_switch, // task switch
    input wire task_trap_flag, // new task trap flag
    input wire mov_done, // move carried out
    input wire undef_opcode, // undefined opcode
    input wire debug_fault, // vector 01h fault
    input wire debug_trap, // vector 01h trap
    input wire break_trap, // vector 03h trap
    input wire [7:0] exc_vector // last vector
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // a move naming slot four or five while extensions are on
    sequence legacy_move;
        mov_valid && cr4_value[3] && (mov_slot[2:1] == 2'b10);
    endsequence
    sequence refused_move;
        (undef_opcode || debug_fault) && !mov_done;
    endsequence
    legacy_refused_a: assert property (legacy_move |=> refused_move)
        else $error("legacy slot move not refused");
    undef_cause_a: assert property
        (undef_opcode |-> $past(mov_valid && cr4_value[3]))
        else $error("undefined opcode without cause");
    step_trap_a: assert property
        (retire_valid && flags_word[8] |=> debug_trap)
        else $error("no single step trap");
    task_trap_a: assert property
        (task_switch && task_trap_flag |=> debug_trap)
        else $error("no task switch trap");
    break_trap_a: assert property
        (retire_valid && fetch_opcode == 8'hcc |=> break_trap)
        else $error("no breakpoint opcode trap");
    break_vector_a: assert property
        (break_trap && !debug_trap && !debug_fault |-> exc_vector == 8'h03)
        else $error("wrong breakpoint vector");
    fault_vector_a: assert property
        (debug_fault && !break_trap |-> exc_vector == 8'h01)
        else $error("wrong fault vector");
    trap_vector_a: assert property
        (debug_trap && !break_trap |-> exc_vector == 8'h01)
        else $error("wrong trap vector");
    move_done_a: assert property (mov_done |-> $past(mov_valid))
        else $error("move done without a move");
endmodule // dbu_unit_props

bind dbu_unit dbu_unit_props chk_u (.clock(clock), .reset_n(reset_n),
    .mov_valid(mov_valid), .mov_slot(mov_slot), .cr4_value(cr4_value),
    .flags_word(flags_word), .fetch_opcode(fetch_opcode),
    .retire_valid(retire_valid), .task_switch(task_switch),
    .task_trap_flag(task_trap_flag), .mov_done(mov_done),
    .undef_opcode(undef_opcode), .debug_fault(debug_fault),
    .debug_trap(debug_trap), .break_trap(break_trap),
    .exc_vector(exc_vector));

// [dv/dbu_core_model.sv]
// core pipeline stand-in that retires instructions on request
`timescale 1ns/1ns
module dbu_core_model (
    input wire clock, // core clock
    input wire ret_req, // retire one instruction
    input wire ret_trap, // its trap flag
    input wire [7:0] ret_op, // its first opcode byte
    output reg retire_valid, // retire pulse
    output reg [31:0] flags_word, // flags of the retiring instr
    output reg [7:0] fetch_opcode // opcode of the retiring instr
);
    initial begin
        retire_valid = 1'b0;
        flags_word = 32'h0;
        fetch_opcode = 8'h90;
    end
    // one retire per request; flags scrambled when nothing retires
    always @(negedge clock) begin
        retire_valid <= ret_req;
        flags_word <= ret_req ? {23'h0, ret_trap, 8'h02} : ~flags_word;
        // after an opcode trap the original byte is back in place
        fetch_opcode <= ret_req ? ret_op : 8'h90;
    end
endmodule // dbu_core_model

// [dv/dbu_unit_tb.sv]
// self-checking bench for the debug breakpoint unit
`timescale 1ns/1ns
module dbu_unit_tb;
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg mov_valid = 1'b0, mov_write = 1'b0, fetch_valid = 1'b0;
    reg cyc_valid = 1'b0, task_switch = 1'b0, task_trap_flag = 1'b0;
    reg ret_req = 1'b0, ret_trap = 1'b0;
    reg cyc_write = 1'b1, cyc_io = 1'b0;
    reg [7:0] ret_op = 8'h90;
    reg [2:0] mov_slot = 3'h0;
    reg [31:0] mov_wdata = 32'h0, cr4_value = 32'h0;
    reg [31:0] fetch_addr = 32'h0, cyc_addr = 32'h0;
    wire retire_valid, mov_done, undef_opcode, debug_fault, debug_trap;
    wire break_trap;
    wire [31:0] flags_word, mov_rdata;
    wire [7:0] fetch_opcode, exc_vector;
    integer errors = 0, checks = 0, cycles = 0;
    dbu_unit dut_u (.clock(clock), .reset_n(reset_n),
        .mov_valid(mov_valid), .mov_write(mov_write), .mov_slot(mov_slot),
        .mov_wdata(mov_wdata), .cr4_value(cr4_value),
        .flags_word(flags_word), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .fetch_opcode(fetch_opcode),
        .retire_valid(retire_valid), .cyc_valid(cyc_valid),
        .cyc_write(cyc_write), .cyc_io(cyc_io), .cyc_addr(cyc_addr),
        .cyc_len(3'h1), .task_switch(task_switch),
        .task_trap_flag(task_trap_flag), .mov_rdata(mov_rdata),
        .mov_done(mov_done), .undef_opcode(undef_opcode),
        .debug_fault(debug_fault), .debug_trap(debug_trap),
        .break_trap(break_trap), .exc_vector(exc_vector));
    dbu_core_model core_u (.clock(clock), .ret_req(ret_req),
        .ret_trap(ret_trap), .ret_op(ret_op), .retire_valid(retire_valid),
        .flags_word(flags_word), .fetch_opcode(fetch_opcode));
    always #4 clock = ~clock;
    task wrap_up;
        begin
            $display("errors %0d checks %0d", errors, checks);
            if (errors == 0 && checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // cut a hang short
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            wrap_up;
        end
    end
    task chk(input [8*8:1] nm, input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // one move, pulsed for one cycle; returns when its answer stands
    task mv(input w, input [2:0] s, input [31:0] d);
        begin
            @(negedge clock);
            mov_valid = 1'b1;
            mov_write = w;
            mov_slot = s;
            mov_wdata = d;
            @(negedge clock);
            mov_valid = 1'b0;
            mov_wdata = ~d;
        end
    endtask
    task rd(input [2:0] s, input [31:0] e);
        begin
            mv(1'b0, s, 32'h0);
            chk("load", mov_rdata, e);
        end
    endtask
    // k: bit0 data cycle, bit1 fetch, bit2 task switch with trap flag
    task ev(input [2:0] k, input [31:0] a);
        begin
            @(negedge clock);
            {task_switch, fetch_valid, cyc_valid} = k;
            task_trap_flag = k[2];
            cyc_addr = a;
            fetch_addr = a;
            @(negedge clock);
            {task_switch, fetch_valid, cyc_valid} = 3'h0;
            cyc_addr = ~a;
        end
    endtask
    task ret(input t, input [7:0] op);
        begin
            @(negedge clock);
            ret_req <= 1'b1;
            ret_trap <= t;
            ret_op <= op;
            @(negedge clock);
            ret_req <= 1'b0;
            @(negedge clock);
        end
    endtask
    initial begin
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        repeat (3) @(negedge clock);
        rd(3'h6, 32'hffff0ff0);
        mv(1'b1, 3'h0, 32'h00001000);
        rd(3'h0, 32'h00001000);
        // legacy slots alias status and control while extensions off
        mv(1'b1, 3'h5, 32'h00000300);
        rd(3'h7, 32'h00000700);
        rd(3'h4, 32'hffff0ff0);
        cr4_value = 32'h8;
        mv(1'b0, 3'h4, 32'h0);
        chk("undef", undef_opcode, 32'h1);
        mv(1'b1, 3'h5, 32'h0);
        chk("undef", undef_opcode, 32'h1);
        cr4_value = 32'h0;
        // data write window: breakpoint 0 enabled, 1 disabled
        mv(1'b1, 3'h1, 32'h00001000);
        mv(1'b1, 3'h7, 32'h00dd0001);
        ev(3'h1, 32'h00001002);
        ret(1'b0, 8'h90);
        chk("trap", debug_trap, 32'h1);
        chk("vector", exc_vector, 32'h1);
        rd(3'h6, 32'hffff0ff3);
        mv(1'b1, 3'h6, 32'h0);
        rd(3'h6, 32'hffff0ff0);
        // execute breakpoint 2 with size 00b, global enable
        mv(1'b1, 3'h2, 32'h00002000);
        mv(1'b1, 3'h7, 32'h00000020);
        ev(3'h2, 32'h00002000);
        chk("fault", debug_fault, 32'h1);
        ret(1'b1, 8'h90);
        chk("trap", debug_trap, 32'h1);
        ret(1'b0, 8'hcc);
        chk("break", break_trap, 32'h1);
        chk("vector", exc_vector, 32'h3);
        // task switch drops local enables, keeps global ones
        mv(1'b1, 3'h7, 32'h00000006);
        ev(3'h4, 32'h0);
        chk("trap", debug_trap, 32'h1);
        rd(3'h7, 32'h00000402);
        // guard turns the next move into a fault and clears itself
        mv(1'b1, 3'h7, 32'h00002000);
        mv(1'b0, 3'h6, 32'h0);
        chk("fault", debug_fault, 32'h1);
        chk("done", mov_done, 32'h0);
        rd(3'h7, 32'h00000400);
        rd(3'h6, 32'hffffeff4);
        // io breakpoint 3 only matches with extensions on
        mv(1'b1, 3'h6, 32'h0);
        mv(1'b1, 3'h3, 32'h00003000);
        mv(1'b1, 3'h7, 32'h20000080);
        cyc_io = 1'b1;
        cyc_write = 1'b0;
        ev(3'h1, 32'h00003000);
        ret(1'b0, 8'h90);
        chk("trap", debug_trap, 32'h0);
        rd(3'h6, 32'hffff0ff0);
        cr4_value = 32'h8;
        ev(3'h1, 32'h00003000);
        ret(1'b0, 8'h90);
        chk("trap", debug_trap, 32'h1);
        rd(3'h6, 32'hffff0ff8);
        // data read: no match for write type, match for read-write type
        cr4_value = 32'h0;
        cyc_io = 1'b0;
        mv(1'b1, 3'h6, 32'h0);
        mv(1'b1, 3'h7, 32'h10000080);
        ev(3'h1, 32'h00003000);
        rd(3'h6, 32'hffff0ff0);
        mv(1'b1, 3'h7, 32'h30000080);
        ev(3'h1, 32'h00003000);
        rd(3'h6, 32'hffff0ff8);
        wrap_up;
    end
endmodule // dbu_unit_tb
